// file: core/brf_consts.svh
/*
 * Constants for the banked register file and stack pointer block.
 * Assumes inclusion by bare name from the design modules.
 */
`ifndef BRF_CONSTS_SVH
`define BRF_CONSTS_SVH

// ==========================================================
// Address map of bank 0
`define BRF_PORT_LAST 8'h03
`define BRF_GP_FIRST 8'h04
`define BRF_GP_LAST 8'hEF
`define BRF_CTRL_FIRST 8'hF0
`define BRF_ADDR_PTR 8'hFD
`define BRF_ADDR_STK_HI 8'hFE
`define BRF_ADDR_STK_LO 8'hFF

// ==========================================================
// Expanded bank codes and pointer fields
`define BRF_BANK_NORMAL 4'h0
`define BRF_BANK_D 4'hD
`define BRF_BANK_F 4'hF
`define BRF_PTR_GROUP_MSB 7
`define BRF_PTR_GROUP_LSB 4
`define BRF_PTR_BANK_MSB 3
`define BRF_PTR_BANK_LSB 0

// ==========================================================
// Reset values
`define BRF_PTR_RESET 8'h00
`define BRF_SP_RESET 8'h00
`define BRF_DATA_RESET 8'h00

`endif

// file: core/brf_pkg.sv
/*
 * Types shared by the register file block.
 * Assumes brf_consts.svh is on the include path.
 */
`default_nettype none
package brf_pkg;
    // Stack operation requested by the core
    typedef enum logic [1:0] {
        BRF_STK_NONE,
        BRF_STK_PUSH,
        BRF_STK_POP
    } brf_stk_type;

    // Which storage an access lands in
    typedef enum logic [2:0] {
        BRF_TGT_PORT,
        BRF_TGT_GP,
        BRF_TGT_CTRL,
        BRF_TGT_BANK_D,
        BRF_TGT_BANK_F,
        BRF_TGT_NONE
    } brf_tgt_type;
endpackage
`default_nettype wire

// file: core/brf_addr_resolve.sv
/*
 * Resolves a 4-bit working or 8-bit direct address into a file address
 * and a storage target, using the working group pointer.
 * Assumes a purely combinational context inside brf_register_file.
 */
`default_nettype none
`include "brf_consts.svh"

module brf_addr_resolve (
    input wire logic [7:0] ptr, // Working group pointer
    input wire logic is_short, // 4-bit working address in use
    input wire logic [7:0] addr_in, // Address from the instruction
    output logic [7:0] addr_out, // Resolved file address
    output brf_pkg::brf_tgt_type tgt // Storage target
);
    import brf_pkg::*;

    // ==========================================================
    // Address resolution
    always_comb begin
        logic [3:0] bank;
        bank = ptr[`BRF_PTR_BANK_MSB:`BRF_PTR_BANK_LSB];
        // Short address: group from pointer upper nibble
        if (is_short) begin
            addr_out = {ptr[`BRF_PTR_GROUP_MSB:`BRF_PTR_GROUP_LSB], addr_in[3:0]};
        end else begin
            addr_out = addr_in;
        end
        // Classify the resolved address
        if (addr_out <= `BRF_PORT_LAST) begin
            tgt = BRF_TGT_PORT;
        end else if (addr_out <= `BRF_GP_LAST) begin
            tgt = BRF_TGT_GP;
        end else begin
            tgt = BRF_TGT_CTRL;
        end
        // Lowest 16 swapped for an expanded bank
        if (addr_out[7:4] == 4'h0 && bank != `BRF_BANK_NORMAL) begin
            if (bank == `BRF_BANK_D) begin
                tgt = BRF_TGT_BANK_D;
            end else if (bank == `BRF_BANK_F) begin
                tgt = BRF_TGT_BANK_F;
            end else begin
                tgt = BRF_TGT_NONE; // Unimplemented bank
            end
        end
    end
endmodule // brf_addr_resolve
`default_nettype wire

// file: core/brf_register_file.sv
/*
 * Banked register file with working group pointer and stack pointers.
 * Assumes a core that issues one read and at most one write or stack
 * operation per cycle; ports, counter/timers and control registers
 * outside are reached through the external window signals.
 */
// Operation
// - Bank 0: ports, general bytes, control
// - Expanded banks D and F exist
// - Any register reachable by 8-bit address
// - Short address: sixteen groups of sixteen
// - Short address formed from group pointer
// - Stack in general bytes, low pointer
// - High pointer byte is general purpose
// - High pointer readable, writable at FEH
// - Low pointer readable, writable at FFH
// - Pointer upper nibble selects working group
// - Pointer lower nibble selects bank
// - Pointer at 253; 0Dh maps timers
`default_nettype none
`include "brf_consts.svh"

module brf_register_file #(
    parameter int GP_WORDS = 237 // General-purpose byte count
) (
    input wire logic clk_sys, // Core clock, 40 MHz
    input wire logic reset, // Asynchronous reset, active high
    input wire logic rd_short, // Read address is 4-bit working address
    input wire logic [7:0] rd_addr, // Read address
    output logic [7:0] rd_data, // Read data, registered
    output logic rd_ext, // Read went to the external window
    input wire logic wr_en, // Write strobe
    input wire logic wr_short, // Write address is 4-bit working address
    input wire logic [7:0] wr_addr, // Write address
    input wire logic [7:0] wr_data, // Write data
    input wire brf_pkg::brf_stk_type stk_op, // Stack push or pop
    input wire logic [7:0] stk_push_data, // Byte to push
    output logic [7:0] stk_pop_data, // Byte popped, registered
    output logic [7:0] ext_addr, // External window address
    output logic [2:0] ext_sel, // External target code
    output logic ext_wr, // External write strobe
    output logic [7:0] ext_wdata, // External write data
    input wire logic [7:0] ext_rdata, // External read data
    output logic [7:0] working_group_pointer, // Pointer value
    output logic [7:0] stack_pointer_bits // Low stack pointer value
);
    import brf_pkg::*;

    // ==========================================================
    // State
    logic [7:0] gp_mem [0:GP_WORDS-1]; // General-purpose bytes
    logic [7:0] ptr_r, ptr_nxt; // Working group pointer
    logic [7:0] stk_hi_r, stk_hi_nxt; // Stack pointer high byte
    logic [7:0] stk_lo_r, stk_lo_nxt; // Stack pointer low byte
    logic [7:0] rd_data_r, rd_data_nxt; // Read data register
    logic rd_ext_r, rd_ext_nxt; // Read target flag
    logic [7:0] pop_r, pop_nxt; // Popped byte register
    logic gp_we; // General store write enable
    logic [7:0] gp_waddr; // General store write address
    logic [7:0] gp_wdata; // General store write data
    logic [7:0] rd_res, wr_res; // Resolved addresses
    brf_tgt_type rd_tgt, wr_tgt; // Resolved targets

    // Index into general store
    function automatic logic [7:0] gp_index(input logic [7:0] a);
        gp_index = a - `BRF_GP_FIRST;
    endfunction

    // Address lies in the general range
    function automatic logic in_gp(input logic [7:0] a);
        in_gp = (a >= `BRF_GP_FIRST) && (a <= `BRF_GP_LAST);
    endfunction

    // ==========================================================
    // Address resolution for read and write
    brf_addr_resolve u_rd_res (
        .ptr(ptr_r),
        .is_short(rd_short),
        .addr_in(rd_addr),
        .addr_out(rd_res),
        .tgt(rd_tgt)
    );

    brf_addr_resolve u_wr_res (
        .ptr(ptr_r),
        .is_short(wr_short),
        .addr_in(wr_addr),
        .addr_out(wr_res),
        .tgt(wr_tgt)
    );

    // ==========================================================
    // Next-state logic
    always_comb begin
        logic [7:0] stk_lo_dec;
        stk_lo_dec = stk_lo_r - 8'h01;
        ptr_nxt = ptr_r;
        stk_hi_nxt = stk_hi_r;
        stk_lo_nxt = stk_lo_r;
        pop_nxt = pop_r;
        gp_we = 1'b0;
        gp_waddr = 8'h00;
        gp_wdata = wr_data;
        ext_wr = 1'b0;
        // Register writes
        if (wr_en) begin
            case (wr_tgt)
                BRF_TGT_GP: begin
                    gp_we = 1'b1;
                    gp_waddr = gp_index(wr_res);
                end
                BRF_TGT_CTRL: begin
                    // Pointer and stack bytes are held here
                    if (wr_res == `BRF_ADDR_PTR) begin
                        ptr_nxt = wr_data;
                    end else if (wr_res == `BRF_ADDR_STK_HI) begin
                        stk_hi_nxt = wr_data;
                    end else if (wr_res == `BRF_ADDR_STK_LO) begin
                        stk_lo_nxt = wr_data;
                    end else begin
                        ext_wr = 1'b1;
                    end
                end
                BRF_TGT_PORT, BRF_TGT_BANK_D, BRF_TGT_BANK_F: begin
                    ext_wr = 1'b1;
                end
                default: begin
                    ext_wr = 1'b0; // Unimplemented bank ignored
                end
            endcase
        end
        // Stack operations win over a same-cycle low stack pointer write
        case (stk_op)
            BRF_STK_PUSH: begin
                stk_lo_nxt = stk_lo_dec;
                if (in_gp(stk_lo_dec)) begin
                    gp_we = 1'b1;
                    gp_waddr = gp_index(stk_lo_dec);
                    gp_wdata = stk_push_data;
                end
            end
            BRF_STK_POP: begin
                stk_lo_nxt = stk_lo_r + 8'h01;
                pop_nxt = in_gp(stk_lo_r) ? gp_mem[gp_index(stk_lo_r)] : `BRF_DATA_RESET;
            end
            default: begin
                stk_lo_nxt = stk_lo_nxt;
            end
        endcase
    end

    // Read path
    always_comb begin
        rd_data_nxt = ext_rdata;
        rd_ext_nxt = 1'b1;
        case (rd_tgt)
            BRF_TGT_GP: begin
                rd_data_nxt = gp_mem[gp_index(rd_res)];
                rd_ext_nxt = 1'b0;
            end
            BRF_TGT_CTRL: begin
                if (rd_res == `BRF_ADDR_PTR) begin
                    rd_data_nxt = ptr_r;
                    rd_ext_nxt = 1'b0;
                end else if (rd_res == `BRF_ADDR_STK_HI) begin
                    rd_data_nxt = stk_hi_r;
                    rd_ext_nxt = 1'b0;
                end else if (rd_res == `BRF_ADDR_STK_LO) begin
                    rd_data_nxt = stk_lo_r;
                    rd_ext_nxt = 1'b0;
                end
            end
            BRF_TGT_NONE: begin
                rd_data_nxt = `BRF_DATA_RESET;
                rd_ext_nxt = 1'b0;
            end
            default: begin
                rd_data_nxt = ext_rdata;
            end
        endcase
    end

    // External window follows an external write if any, else the read
    always_comb begin
        ext_addr = ext_wr ? wr_res : rd_res;
        ext_sel = ext_wr ? 3'(wr_tgt) : 3'(rd_tgt);
        ext_wdata = wr_data;
    end

    // ==========================================================
    // Registers
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            ptr_r <= `BRF_PTR_RESET;
            stk_hi_r <= `BRF_SP_RESET;
            stk_lo_r <= `BRF_SP_RESET;
            rd_data_r <= `BRF_DATA_RESET;
            rd_ext_r <= 1'b0;
            pop_r <= `BRF_DATA_RESET;
        end else begin
            ptr_r <= ptr_nxt;
            stk_hi_r <= stk_hi_nxt;
            stk_lo_r <= stk_lo_nxt;
            rd_data_r <= rd_data_nxt;
            rd_ext_r <= rd_ext_nxt;
            pop_r <= pop_nxt;
        end
    end

    // General store, no reset
    always_ff @(posedge clk_sys) begin
        if (gp_we) begin
            gp_mem[gp_waddr] <= gp_wdata;
        end
    end

    assign rd_data = rd_data_r;
    assign rd_ext = rd_ext_r;
    assign stk_pop_data = pop_r;
    assign working_group_pointer = ptr_r;
    assign stack_pointer_bits = stk_lo_r;
endmodule // brf_register_file
`default_nettype wire

// file: bench/brf_register_file_props.sv
/*
 * Checker for the banked register file: pointer, stack and window timing.
 * Assumes it is bound to brf_register_file and sees only its ports.
 */
`default_nettype none
module brf_register_file_props #(
    parameter int GP_WORDS = 237 // General byte count
) (
    input wire logic clk_sys, // Core clock
    input wire logic reset, // Async reset
    input wire logic rd_short, // Short read
    input wire logic [7:0] rd_addr, // Read address
    input wire logic [7:0] rd_data, // Read data
    input wire logic rd_ext, // Read from window
    input wire logic wr_en, // Write strobe
    input wire logic wr_short, // Short write
    input wire logic [7:0] wr_addr, // Write address
    input wire logic [7:0] wr_data, // Write data
    input wire brf_pkg::brf_stk_type stk_op, // Stack op
    input wire logic [7:0] stk_push_data, // Pushed byte
    input wire logic [7:0] stk_pop_data, // Popped byte
    input wire logic [7:0] ext_addr, // Window address
    input wire logic [2:0] ext_sel, // Window target
    input wire logic [7:0] ext_rdata, // Window data
    input wire logic [7:0] working_group_pointer, // Pointer
    input wire logic [7:0] stack_pointer_bits // Low stack pointer
);
    timeunit 1ns;
    timeprecision 100ps;
    import brf_pkg::*;
    // =============================================
    // Clocking and stack sequence
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);
    // Push that stores, then pop at once
    sequence s_push_pop;
        !wr_en && stk_op == BRF_STK_PUSH && stack_pointer_bits inside {[8'h05:8'hF0]}
        ##1 !wr_en && stk_op == BRF_STK_POP;
    endsequence
    // =============================================
    // Assertions
    chk_ptr_write:
    assert property (wr_en && !wr_short && wr_addr == 8'hFD |=> working_group_pointer == $past(wr_data))
        else $error("pointer write lost");
    chk_stk_lo_write:
    assert property (wr_en && !wr_short && wr_addr == 8'hFF && stk_op == BRF_STK_NONE
        |=> stack_pointer_bits == $past(wr_data)) else $error("low stack pointer write lost");
    chk_push_dec:
    assert property (stk_op == BRF_STK_PUSH |=> stack_pointer_bits == $past(stack_pointer_bits) - 8'h01)
        else $error("push did not decrement");
    chk_pop_inc:
    assert property (stk_op == BRF_STK_POP |=> stack_pointer_bits == $past(stack_pointer_bits) + 8'h01)
        else $error("pop did not increment");
    chk_sp_hold:
    assert property (stk_op == BRF_STK_NONE && !wr_en |=> $stable(stack_pointer_bits))
        else $error("stack pointer moved while idle");
    chk_push_pop_pair:
    assert property (s_push_pop |=> stk_pop_data == $past(stk_push_data, 2))
        else $error("popped byte differs from pushed byte");
    chk_short_map:
    assert property (rd_short && !wr_en |-> ext_addr == {working_group_pointer[7:4], rd_addr[3:0]})
        else $error("short address resolved wrongly");
    chk_bank_d_sel:
    assert property (rd_short && !wr_en && working_group_pointer == 8'h0D |-> ext_sel == BRF_TGT_BANK_D)
        else $error("bank D not selected");
    chk_ext_read:
    assert property (!wr_en && ext_sel != BRF_TGT_GP && ext_sel != BRF_TGT_NONE && ext_addr < 8'hFD
        |=> rd_ext && rd_data == $past(ext_rdata)) else $error("window read not returned");
    chk_gp_local:
    assert property (!wr_en && !rd_short && rd_addr inside {[8'h10:8'hEF]} |=> !rd_ext)
        else $error("general byte read went outside");
endmodule // brf_register_file_props

bind brf_register_file brf_register_file_props #(.GP_WORDS(GP_WORDS)) i_props (.clk_sys, .reset,
    .rd_short, .rd_addr, .rd_data, .rd_ext, .wr_en, .wr_short, .wr_addr, .wr_data, .stk_op,
    .stk_push_data, .stk_pop_data, .ext_addr, .ext_sel, .ext_rdata, .working_group_pointer,
    .stack_pointer_bits);
`default_nettype wire

// file: bench/brf_window_model.sv
/*
 * Model of the storage outside the window: ports, control, banks D and F.
 * Assumes reads are combinational and writes land on the clock edge.
 */
`default_nettype none
module brf_window_model (
    input wire logic clk_sys, // Core clock
    input wire logic [7:0] ext_addr, // Window address
    input wire logic [2:0] ext_sel, // Target code
    input wire logic ext_wr, // Write strobe
    input wire logic [7:0] ext_wdata, // Write data
    output logic [7:0] ext_rdata // Read data, same cycle
);
    timeunit 1ns;
    timeprecision 100ps;
    import brf_pkg::*;
    logic [7:0] mem_r [0:2047] = '{default: 8'h00}; // One page per target code, known at start
    // Store writes to ports, control and expanded banks
    always @(posedge clk_sys) begin
        if (ext_wr && ext_sel != BRF_TGT_NONE) begin
            mem_r[{ext_sel, ext_addr}] <= ext_wdata;
        end
    end
    // Unmapped targets read a fixed pattern, not stale data
    assign ext_rdata = (ext_sel == BRF_TGT_NONE) ? 8'hA5 : mem_r[{ext_sel, ext_addr}];
endmodule // brf_window_model
`default_nettype wire

// file: bench/brf_register_file_bench.sv
/*
 * Bench: register, short address, bank and stack tests through the core ports.
 * Assumes the core files, checker and window model are compiled first.
 */
`default_nettype none
module brf_register_file_bench;
    timeunit 1ns;
    timeprecision 100ps;
    import brf_pkg::*;
    logic clk_sys = 0, reset = 1, rd_short = 0, wr_en = 0, wr_short = 0, rd_ext, ext_wr;
    logic [7:0] rd_addr = 0, wr_addr = 0, wr_data = 0, stk_push_data = 0, rd_data, stk_pop_data;
    logic [7:0] ext_addr, ext_wdata, ext_rdata, working_group_pointer, stack_pointer_bits;
    logic [2:0] ext_sel;
    brf_stk_type stk_op = BRF_STK_NONE;
    int err_count = 0, checks = 0;
    logic [7:0] ptrs [3] = '{8'h00, 8'h0D, 8'h0F}; // Bank 0, D, F
    logic [2:0] sels [3] = '{3'h0, 3'h3, 3'h4}; // Expected targets
    always #12.5 clk_sys = ~clk_sys;
    brf_register_file #(.GP_WORDS(237)) i_dut (.clk_sys, .reset, .rd_short, .rd_addr, .rd_data,
        .rd_ext, .wr_en, .wr_short, .wr_addr, .wr_data, .stk_op, .stk_push_data, .stk_pop_data,
        .ext_addr, .ext_sel, .ext_wr, .ext_wdata, .ext_rdata, .working_group_pointer,
        .stack_pointer_bits);
    brf_window_model i_win (.clk_sys, .ext_addr, .ext_sel, .ext_wr, .ext_wdata, .ext_rdata);
    // =============================================
    // Access tasks
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic s, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        wr_en <= 1'b1;
        wr_short <= s;
        wr_addr <= a;
        wr_data <= d;
        @(posedge clk_sys);
        wr_en <= 1'b0;
        #1;
    endtask
    // Read data and source flag land one cycle after the request
    task automatic rd(input logic s, input logic [7:0] a, input logic [7:0] exp, input logic x);
        @(posedge clk_sys);
        rd_short <= s;
        rd_addr <= a;
        @(posedge clk_sys);
        #1;
        chk(rd_data, exp);
        chk({7'h0, rd_ext}, {7'h0, x});
    endtask
    task automatic stk(input brf_stk_type op, input logic [7:0] d);
        @(posedge clk_sys);
        stk_op <= op;
        stk_push_data <= d;
        @(posedge clk_sys);
        stk_op <= BRF_STK_NONE;
        #1;
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // =============================================
    // Tests
    initial begin
        repeat (20) @(posedge clk_sys);
        reset <= 1'b0;
        #1;
        chk(working_group_pointer, 8'h00);
        chk(stack_pointer_bits, 8'h00);
        $display("test reset done");
        wr(1'b0, 8'hFD, 8'h70);
        chk(working_group_pointer, 8'h70);
        wr(1'b0, 8'hFE, 8'h3C);
        rd(1'b0, 8'hFE, 8'h3C, 1'b0);
        wr(1'b0, 8'hFF, 8'hE0);
        chk(stack_pointer_bits, 8'hE0);
        rd(1'b0, 8'hFF, 8'hE0, 1'b0);
        $display("test registers done");
        wr(1'b0, 8'hEF, 8'h11);
        rd(1'b0, 8'hEF, 8'h11, 1'b0);
        wr(1'b1, 8'h05, 8'h22);
        rd(1'b0, 8'h75, 8'h22, 1'b0);
        rd(1'b1, 8'h05, 8'h22, 1'b0);
        $display("test working groups done");
        for (int i = 0; i < 3; i++) begin
            wr(1'b0, 8'hFD, ptrs[i]);
            wr(1'b1, 8'h01, 8'(8'h90 + i));
            rd(1'b1, 8'h01, 8'(8'h90 + i), 1'b1);
            chk({5'h0, ext_sel}, {5'h0, sels[i]});
        end
        wr(1'b0, 8'hF5, 8'h66);
        rd(1'b0, 8'hF5, 8'h66, 1'b1);
        chk({5'h0, ext_sel}, 8'h02);
        wr(1'b0, 8'hFD, 8'h01);
        wr(1'b1, 8'h02, 8'h77);
        rd(1'b1, 8'h02, 8'h00, 1'b0);
        chk({5'h0, ext_sel}, 8'h05);
        $display("test banks done");
        wr(1'b0, 8'hFF, 8'hE0);
        stk(BRF_STK_PUSH, 8'hA5);
        chk(stack_pointer_bits, 8'hDF);
        stk(BRF_STK_PUSH, 8'h5A);
        chk(stack_pointer_bits, 8'hDE);
        rd(1'b0, 8'hDF, 8'hA5, 1'b0);
        stk(BRF_STK_POP, 8'h00);
        chk(stk_pop_data, 8'h5A);
        stk(BRF_STK_POP, 8'h00);
        chk(stk_pop_data, 8'hA5);
        chk(stack_pointer_bits, 8'hE0);
        @(posedge clk_sys);
        stk_op <= BRF_STK_PUSH;
        stk_push_data <= 8'h3C;
        @(posedge clk_sys);
        stk_op <= BRF_STK_POP;
        @(posedge clk_sys);
        stk_op <= BRF_STK_NONE;
        #1;
        chk(stk_pop_data, 8'h3C);
        chk(stack_pointer_bits, 8'hE0);
        wr(1'b0, 8'hFF, 8'hFF);
        stk(BRF_STK_POP, 8'h00);
        chk(stack_pointer_bits, 8'h00);
        $display("test stack done");
        results();
    end
    // Cut a hang short well after the tests should finish
    initial begin
        repeat (3000) @(posedge clk_sys);
        err_count++;
        $display("wrong value at %0t ns: watchdog expired", $time);
        results();
    end
endmodule // brf_register_file_bench
`default_nettype wire
